// ==== inc/spiem_defines.svh ====
// offsets, field positions and reset values of the event mask and underrun block
`ifndef SPIEM_DEFINES_SVH
`define SPIEM_DEFINES_SVH
// register indices; byte address is four times the index
`define SPIEM_IDX_STATH     12'h2B6
`define SPIEM_IDX_EVEN      12'h2C0
`define SPIEM_IDX_WMCTL     12'h2C2
`define SPIEM_IDX_URLO      12'h2C4
`define SPIEM_IDX_URHI      12'h2C6
`define SPIEM_IDX_CTRL      12'h2C8
`define SPIEM_IDX_FLAGS     12'h2CA
`define SPIEM_IDX_ISTAT     12'h2CC
`define SPIEM_IDX_IMASK     12'h2CE
// event enable and interrupt status layout
`define SPIEM_EV_RXFULL     0
`define SPIEM_EV_TXFULL     1
`define SPIEM_EV_TXEMPTY    3
`define SPIEM_EV_RXWM       4
`define SPIEM_EV_TXWM       5
`define SPIEM_EV_UNDERRUN   8
`define SPIEM_EV_IMPL       16'h013B
`define SPIEM_EVEN_IMPL     16'h010B
// watermark control layout
`define SPIEM_WM_RXEN       15
`define SPIEM_WM_RXLSB      8
`define SPIEM_WM_TXEN       7
`define SPIEM_WM_TXLSB      0
// control layout
`define SPIEM_CTL_ENH       0
`define SPIEM_CTL_UREN      1
`define SPIEM_CTL_WLLSB     8
// reset value of every register except the flags register, whose transmit-empty bit resets to one
`define SPIEM_RST16         16'h0000
// word length break points in bits
`define SPIEM_LEN8          6'h08
`define SPIEM_LEN16         6'h10
`define SPIEM_LEN24         6'h18
`define SPIEM_LEN32         6'h20
`define SPIEM_RDZERO        32'h0000_0000
`endif

// ==== inc/spiem_pkg.sv ====
// types shared by the event mask and underrun block
package spiem_pkg;
  typedef logic [5:0]  spiem_cnt_t;
  typedef logic [15:0] spiem_reg_t;
  typedef enum logic {SH_IDLE, SH_RUN} spiem_shift_e;
endpackage

// ==== inc/spiem_ur_if.sv ====
// carrier between the top and the underrun word selector
interface spiem_ur_if;
  logic [31:0]       word;
  logic [4:0]        wlen;
  logic [31:0]       sel_word;
  spiem_pkg::spiem_cnt_t nbits;
  modport src (output word, output wlen, input sel_word, input nbits);
  modport sel (input word, input wlen, output sel_word, output nbits);
endinterface

// ==== rtl/spiem_ursel.sv ====
// underrun word selection by word length
`include "spiem_defines.svh"
module spiem_ursel (
  input  wire logic clk,
  input  wire logic rst,
  spiem_ur_if.sel   ur
);
  spiem_pkg::spiem_cnt_t nbits_nxt;
  logic [31:0]           word_nxt;

  // field value zero stands for a full 32 bit word
  assign nbits_nxt = (ur.wlen == 5'h00) ? `SPIEM_LEN32 : 6'({1'b0, ur.wlen} + 6'h01);
  assign word_nxt  = (nbits_nxt > `SPIEM_LEN24) ? ur.word :
                     (nbits_nxt > `SPIEM_LEN16) ? {8'h00, ur.word[23:0]} :
                     (nbits_nxt > `SPIEM_LEN8)  ? {16'h0000, ur.word[15:0]} :
                                                  {24'h000000, ur.word[7:0]};

  always_ff @(posedge clk) begin
    if (rst) begin
      ur.nbits    <= 6'h00;
      ur.sel_word <= 32'h0000_0000;
    end else begin
      ur.nbits    <= nbits_nxt;
      ur.sel_word <= word_nxt;
    end
  end

  short_word_a: assert property (@(posedge clk) disable iff (rst)
    (ur.nbits <= `SPIEM_LEN8) |-> (ur.sel_word[31:8] == 24'h000000))
    else $error("short word carries high bits");
endmodule // spiem_ursel

// ==== rtl/spiem_top.sv ====
// event masking, watermark and underrun word logic of a serial port
// Overview of operation
// - with the transmit-empty enable set an empty transmit buffer raises an event, else none.
// - with the transmit-full enable set a full transmit buffer raises an event, else none.
// - with the receive-full enable set a full receive buffer raises an event, else none.
// - with its enable set the receive watermark fires while threshold <= receive count.
// - with its enable set the transmit watermark fires only while threshold == transmit count.
// - a threshold above the buffer depth never matches.
// - threshold bit 2 exists from depth 8, bit 3 from depth 16, bit 4 only at depth 32.
// - with the underrun word enabled an underrun shifts out the stored 32 bit word.
// - 9 to 16 bit words send the low 16 bits, 2 to 8 bit words the low 8 bits.
// - 25 to 32 bit words use all 32 bits of the stored word, 17 to 24 bit words the low 24 bits.
// - watermark fields and underrun word are read and write and reset to zero.
// - six bit element counts are kept by hardware and feed the watermark compares.
// - in standard mode a buffer write sets transmit-full and a shift register load clears it.
// - in standard mode a received word sets receive-full and a buffer read clears it.
//
// Design decision made here: register access over Avalon-MM.
`include "spiem_defines.svh"
module spiem_top #(
  parameter int QUEUE_DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        tx_push,
  input  wire logic        tx_pop,
  input  wire logic        rx_push,
  input  wire logic        rx_pop,
  input  wire logic        tx_underrun_flag,
  input  wire logic        sclk,
  input  wire logic        ss_n,
  output logic             sdo,
  output logic             sdo_oe_n,
  output logic             irq_event,
  output logic             tx_buffer_full_flag,
  output logic             tx_buffer_empty_flag,
  output logic             rx_buffer_full_flag,
  output logic [5:0]       tx_element_count,
  output logic [5:0]       rx_element_count
);
  localparam spiem_pkg::spiem_cnt_t QD = 6'(QUEUE_DEPTH);
  // unimplemented threshold bits are tied to zero so software sees the depth
  localparam spiem_pkg::spiem_cnt_t THR_IMPL = {QUEUE_DEPTH >= 32, QUEUE_DEPTH >= 32,
                                                QUEUE_DEPTH >= 16, QUEUE_DEPTH >= 8,
                                                2'b11};

  spiem_pkg::spiem_reg_t   even_r, wm_r, urlo_r, urhi_r, ctrl_r, istat_r, imask_r;
  spiem_pkg::spiem_reg_t   istat_nxt, cond;
  spiem_pkg::spiem_cnt_t   tx_cnt_r, rx_cnt_r, tx_cnt_nxt, rx_cnt_nxt;
  spiem_pkg::spiem_cnt_t   rx_thr, tx_thr, bits_r;
  spiem_pkg::spiem_shift_e state_r;
  logic                    wait_r, irq_r, evt_r, sdo_r, oe_n_r;
  logic                    txf_std_r, rxf_std_r, txf_r, txe_r, rxf_r;
  logic [31:0]             rdata_r, rd_mux, shift_r, aligned;
  logic [11:0]             idx;
  logic                    acc, wr, rd, lo_we, hi_we;
  logic                    s_even, s_wm, s_urlo, s_urhi, s_ctrl, s_flags, s_istat, s_imask, s_stath;
  logic                    enh, ur_en, tx_full, tx_empty, rx_full, rx_wm, tx_wm;
  logic                    sclk_s1_r, sclk_s2_r, sclk_s3_r, ss_s1_r, ss_s2_r, sclk_fall, ur_start;
  spiem_pkg::spiem_reg_t   wmask;

  spiem_ur_if ur_bus ();
  spiem_ursel u_ursel (
    .clk (clk),
    .rst (rst),
    .ur  (ur_bus.sel)
  );
  assign ur_bus.word = {urhi_r, urlo_r};
  assign ur_bus.wlen = ctrl_r[`SPIEM_CTL_WLLSB +: 5];

  // bus decode: one wait state, access happens where waitrequest is low
  assign idx     = avs_address[13:2];
  assign acc     = (avs_read | avs_write) & ~wait_r;
  assign wr      = acc & avs_write;
  assign rd      = acc & avs_read;
  assign s_stath = (idx == `SPIEM_IDX_STATH);
  assign s_even  = (idx == `SPIEM_IDX_EVEN);
  assign s_wm    = (idx == `SPIEM_IDX_WMCTL);
  assign s_urlo  = (idx == `SPIEM_IDX_URLO);
  assign s_urhi  = (idx == `SPIEM_IDX_URHI);
  assign s_ctrl  = (idx == `SPIEM_IDX_CTRL);
  assign s_flags = (idx == `SPIEM_IDX_FLAGS);
  assign s_istat = (idx == `SPIEM_IDX_ISTAT);
  assign s_imask = (idx == `SPIEM_IDX_IMASK);
  assign wmask   = {{8{hi_we}}, {8{lo_we}}};
  assign lo_we   = avs_byteenable[0];
  assign hi_we   = avs_byteenable[1];

  always_comb begin
    rd_mux = `SPIEM_RDZERO;
    if (s_stath) begin
      rd_mux = {18'h00000, rx_cnt_r, 2'b00, tx_cnt_r};
    end else if (s_even) begin
      rd_mux = {16'h0000, even_r};
    end else if (s_wm) begin
      rd_mux = {16'h0000, wm_r};
    end else if (s_urlo) begin
      rd_mux = {16'h0000, urlo_r};
    end else if (s_urhi) begin
      rd_mux = {16'h0000, urhi_r};
    end else if (s_ctrl) begin
      rd_mux = {16'h0000, ctrl_r};
    end else if (s_flags) begin
      rd_mux = {28'h0000000, txe_r, 1'b0, txf_r, rxf_r};
    end else if (s_istat) begin
      rd_mux = {16'h0000, istat_r};
    end else if (s_imask) begin
      rd_mux = {16'h0000, imask_r};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_r  <= 1'b1;
      rdata_r <= `SPIEM_RDZERO;
    end else begin
      wait_r  <= ~((avs_read | avs_write) & wait_r);
      rdata_r <= (avs_read & wait_r) ? rd_mux : rdata_r;
    end
  end
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;

  // software registers, byte lanes honoured
  always_ff @(posedge clk) begin
    if (rst) begin
      even_r  <= `SPIEM_RST16;
      wm_r    <= `SPIEM_RST16;
      urlo_r  <= `SPIEM_RST16;
      urhi_r  <= `SPIEM_RST16;
      ctrl_r  <= `SPIEM_RST16;
      imask_r <= `SPIEM_RST16;
    end else if (wr) begin
      if (s_even)  even_r  <= (even_r & ~wmask) | (avs_writedata[15:0] & wmask & `SPIEM_EVEN_IMPL);
      if (s_wm)    wm_r    <= (wm_r & ~wmask) | (avs_writedata[15:0] & wmask &
                              {1'b1, 1'b0, THR_IMPL, 1'b1, 1'b0, THR_IMPL});
      if (s_urlo)  urlo_r  <= (urlo_r & ~wmask) | (avs_writedata[15:0] & wmask);
      if (s_urhi)  urhi_r  <= (urhi_r & ~wmask) | (avs_writedata[15:0] & wmask);
      if (s_ctrl)  ctrl_r  <= (ctrl_r & ~wmask) | (avs_writedata[15:0] & wmask & 16'h1F03);
      if (s_imask) imask_r <= (imask_r & ~wmask) | (avs_writedata[15:0] & wmask & `SPIEM_EV_IMPL);
    end
  end

  // element counts saturate at the depth and at zero
  assign enh        = ctrl_r[`SPIEM_CTL_ENH];
  assign ur_en      = ctrl_r[`SPIEM_CTL_UREN];
  assign tx_cnt_nxt = (tx_push & ~tx_pop & (tx_cnt_r != QD))    ? 6'(tx_cnt_r + 6'h01) :
                      (tx_pop & ~tx_push & (tx_cnt_r != 6'h00)) ? 6'(tx_cnt_r - 6'h01) :
                                                                  tx_cnt_r;
  assign rx_cnt_nxt = (rx_push & ~rx_pop & (rx_cnt_r != QD))    ? 6'(rx_cnt_r + 6'h01) :
                      (rx_pop & ~rx_push & (rx_cnt_r != 6'h00)) ? 6'(rx_cnt_r - 6'h01) :
                                                                  rx_cnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_cnt_r  <= 6'h00;
      rx_cnt_r  <= 6'h00;
      txf_std_r <= 1'b0;
      rxf_std_r <= 1'b0;
    end else begin
      tx_cnt_r  <= tx_cnt_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      txf_std_r <= tx_push | (txf_std_r & ~tx_pop);
      rxf_std_r <= rx_push | (rxf_std_r & ~rx_pop);
    end
  end

  assign tx_full  = enh ? (tx_cnt_r == QD) : txf_std_r;
  assign tx_empty = enh ? (tx_cnt_r == 6'h00) : ~txf_std_r;
  assign rx_full  = enh ? (rx_cnt_r == QD) : rxf_std_r;
  assign rx_thr   = wm_r[`SPIEM_WM_RXLSB +: 6];
  assign tx_thr   = wm_r[`SPIEM_WM_TXLSB +: 6];
  // thresholds above the depth are invalid and never match
  assign rx_wm    = wm_r[`SPIEM_WM_RXEN] & (rx_thr <= QD) & (rx_thr <= rx_cnt_r);
  assign tx_wm    = wm_r[`SPIEM_WM_TXEN] & (tx_thr <= QD) & (tx_thr == tx_cnt_r);

  always_comb begin
    cond                     = 16'h0000;
    cond[`SPIEM_EV_RXFULL]   = even_r[`SPIEM_EV_RXFULL] & rx_full;
    cond[`SPIEM_EV_TXFULL]   = even_r[`SPIEM_EV_TXFULL] & tx_full;
    cond[`SPIEM_EV_TXEMPTY]  = even_r[`SPIEM_EV_TXEMPTY] & tx_empty;
    cond[`SPIEM_EV_RXWM]     = rx_wm;
    cond[`SPIEM_EV_TXWM]     = tx_wm;
    cond[`SPIEM_EV_UNDERRUN] = even_r[`SPIEM_EV_UNDERRUN] & tx_underrun_flag;
  end
  // only bits already reported are cleared, so an event in the wait cycle is not lost; set wins
  assign istat_nxt = cond | (istat_r & ~((rd & s_istat) ? rdata_r[15:0] : 16'h0000));

  always_ff @(posedge clk) begin
    if (rst) begin
      istat_r <= `SPIEM_RST16;
      irq_r   <= 1'b0;
      evt_r   <= 1'b0;
      txf_r   <= 1'b0;
      txe_r   <= 1'b1;
      rxf_r   <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_r   <= |(istat_nxt & imask_r);
      evt_r   <= |cond;
      txf_r   <= tx_full;
      txe_r   <= tx_empty;
      rxf_r   <= rx_full;
    end
  end
  assign irq                  = irq_r;
  assign irq_event            = evt_r;
  assign tx_buffer_full_flag  = txf_r;
  assign tx_buffer_empty_flag = txe_r;
  assign rx_buffer_full_flag  = rxf_r;
  assign tx_element_count     = tx_cnt_r;
  assign rx_element_count     = rx_cnt_r;

  // link pins: two stages before use, third stage only for the edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      ss_s1_r   <= 1'b1;
      ss_s2_r   <= 1'b1;
    end else begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      ss_s1_r   <= ss_n;
      ss_s2_r   <= ss_s1_r;
    end
  end
  assign sclk_fall = sclk_s3_r & ~sclk_s2_r;
  assign ur_start  = ur_en & tx_underrun_flag & ~ss_s2_r & (state_r == spiem_pkg::SH_IDLE);
  assign aligned   = ur_bus.sel_word << 6'(`SPIEM_LEN32 - ur_bus.nbits);

  // underrun word goes out msb first, one bit per falling serial clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= spiem_pkg::SH_IDLE;
      shift_r <= 32'h0000_0000;
      bits_r  <= 6'h00;
      sdo_r   <= 1'b0;
      oe_n_r  <= 1'b1;
    end else begin
      case (state_r)
        spiem_pkg::SH_IDLE: begin
          if (ur_start) begin
            state_r <= spiem_pkg::SH_RUN;
            sdo_r   <= aligned[31];
            shift_r <= aligned << 1;
            bits_r  <= 6'(ur_bus.nbits - 6'h01);
            oe_n_r  <= 1'b0;
          end
        end
        spiem_pkg::SH_RUN: begin
          // deselect aborts the word; no clock edges are trusted outside a frame
          if (ss_s2_r || (sclk_fall && bits_r == 6'h00)) begin
            state_r <= spiem_pkg::SH_IDLE;
            oe_n_r  <= 1'b1;
          end else if (sclk_fall) begin
            sdo_r   <= shift_r[31];
            shift_r <= shift_r << 1;
            bits_r  <= 6'(bits_r - 6'h01);
          end
        end
        default: state_r <= spiem_pkg::SH_IDLE;
      endcase
    end
  end
  assign sdo      = sdo_r;
  assign sdo_oe_n = oe_n_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  tx_empty_ev_a: assert property ((even_r[3] && tx_empty) |=> (istat_r[3] && evt_r))
    else $error("transmit empty event missing");
  tx_full_ev_a: assert property ((even_r[1] && tx_full) |=> (istat_r[1] && evt_r))
    else $error("transmit full event missing");
  rx_full_ev_a: assert property ((even_r[0] && rx_full) |=> istat_r[0])
    else $error("receive full event missing");
  rx_wm_fire_a: assert property ((wm_r[15] && rx_thr <= QD && rx_thr <= rx_cnt_r) |=> istat_r[4])
    else $error("receive watermark missed");
  tx_wm_only_a: assert property ((tx_thr != tx_cnt_r) |-> !tx_wm)
    else $error("transmit watermark without equality");
  thr_invalid_a: assert property (((rx_thr > QD) |-> !rx_wm) and ((tx_thr > QD) |-> !tx_wm))
    else $error("invalid threshold matched");
  thr_bits_a: assert property (((rx_thr | tx_thr) & ~THR_IMPL) == 6'h00)
    else $error("unimplemented threshold bit set");
  ur_shift_a: assert property (ur_start |=> (!oe_n_r && state_r == spiem_pkg::SH_RUN))
    else $error("underrun word did not start");
  ur_ignored_a: assert property ((!ur_en && state_r == spiem_pkg::SH_IDLE) |=> oe_n_r)
    else $error("underrun word sent while disabled");
  reset_zero_a: assert property (disable iff (1'b0) rst |=> (wm_r == 16'h0000 && urlo_r == 16'h0000 && urhi_r == 16'h0000))
    else $error("registers not zero after reset");
  count_step_a: assert property ((tx_push && !tx_pop && tx_cnt_r < QD) |=> tx_cnt_r == $past(tx_cnt_r) + 6'h01)
    else $error("transmit count did not step");
  txf_std_a: assert property ((!enh && tx_pop && !tx_push) |=> ##1 !txf_r)
    else $error("transmit full not cleared");
  rxf_std_a: assert property ((!enh && rx_push) |=> ##1 rxf_r)
    else $error("receive full not set");
  evt_or_a: assert property ((cond != 16'h0000) |=> evt_r)
    else $error("interrupt event missing");

  wm_cover_c: cover property (rx_wm ##1 tx_wm);
  ur_cover_c: cover property ((state_r == spiem_pkg::SH_RUN) ##[1:200] (state_r == spiem_pkg::SH_IDLE));
  irq_cover_c: cover property ($rose(irq_r) ##[1:20] (rd && s_istat));
endmodule // spiem_top

// ==== tb/spiem_link_model.sv ====
// far-side serial controller that selects the port and clocks out the underrun word
module spiem_link_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [5:0]  nbits,
  input  wire logic        sdo,
  input  wire logic        sdo_oe_n,
  output logic             sclk,
  output logic             ss_n,
  output logic [31:0]      got,
  output logic             drove,
  output logic             done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    got = 32'h0000_0000;
    drove = 1'b0;
    done = 1'b0;
  end
  // the serial clock stands still between frames; 48 ns period inside one
  always @(posedge go) begin : frame_b
    int i;
    done = 1'b0;
    drove = 1'b0;
    got = 32'h0000_0000;
    ss_n = 1'b0;
    for (i = 0; i < 40 && sdo_oe_n !== 1'b0; i++) @(posedge clk);
    if (sdo_oe_n === 1'b0) begin
      drove = 1'b1;
      #7;
      // sample on the rising edge; the port moves data after each falling edge
      for (i = 0; i < nbits; i++) begin
        #24 sclk = 1'b1;
        got = {got[30:0], sdo};
        #24 sclk = 1'b0;
      end
      #40;
    end
    ss_n = 1'b1;
    done = 1'b1;
  end
endmodule // spiem_link_model

// ==== tb/test_spi_event_mask_and_underrun_data.sv ====
// self-checking bench for the event mask, watermark and underrun word block
`include "spiem_defines.svh"
module test_spi_event_mask_and_underrun_data;
  timeunit 1ns;
  timeprecision 1ps;
  // depth 8 keeps fills short and leaves threshold bits 5:3 absent
  localparam int DEPTH = 8;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdq, got;
  logic [3:0]  avs_byteenable;
  logic        tx_push, tx_pop, rx_push, rx_pop, tx_underrun_flag, sclk, ss_n;
  logic        sdo, sdo_oe_n, irq_event, go, drove, done;
  logic        tx_buffer_full_flag, tx_buffer_empty_flag, rx_buffer_full_flag;
  logic [5:0]  tx_element_count, rx_element_count, nbits;
  int          n_errors = 0;
  int          cmp_count = 0;
  spiem_top #(.QUEUE_DEPTH(DEPTH)) spiem_top_inst (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .tx_push(tx_push), .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop),
    .tx_underrun_flag(tx_underrun_flag), .sclk(sclk), .ss_n(ss_n), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .irq_event(irq_event), .tx_buffer_full_flag(tx_buffer_full_flag),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .rx_buffer_full_flag(rx_buffer_full_flag),
    .tx_element_count(tx_element_count), .rx_element_count(rx_element_count));
  spiem_link_model spiem_link_model_inst (
    .clk(clk), .go(go), .nbits(nbits), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sclk(sclk),
    .ss_n(ss_n), .got(got), .drove(drove), .done(done));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected flag at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [11:0] idx, input logic [15:0] d);
    int i;
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {16'h0000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rdq = avs_readdata;
    if (i == 20) begin
      n_errors++;
      tally_and_finish;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle strobe on {tx_push, tx_pop, rx_push, rx_pop}, then let flags settle
  task automatic pulse(input logic [3:0] p);
    {tx_push, tx_pop, rx_push, rx_pop} <= p;
    @(posedge clk);
    {tx_push, tx_pop, rx_push, rx_pop} <= 4'h0;
    tick(4);
  endtask
  task automatic regs_check;
    bus(0, `SPIEM_IDX_WMCTL, 16'h0000); chk_val(rdq, 32'h0000_0000);
    bus(0, `SPIEM_IDX_URLO, 16'h0000); chk_val(rdq, 32'h0000_0000);
    bus(0, `SPIEM_IDX_URHI, 16'h0000); chk_val(rdq, 32'h0000_0000);
    bus(1, `SPIEM_IDX_WMCTL, 16'hFFFF);
    bus(0, `SPIEM_IDX_WMCTL, 16'h0000); chk_val(rdq, 32'h0000_8787);
    avs_byteenable <= 4'h1;
    bus(1, `SPIEM_IDX_WMCTL, 16'h0000);
    avs_byteenable <= 4'hF;
    bus(0, `SPIEM_IDX_WMCTL, 16'h0000); chk_val(rdq, 32'h0000_8700);
    bus(1, `SPIEM_IDX_WMCTL, 16'h0000);
    bus(1, `SPIEM_IDX_URLO, 16'h5A3D);
    bus(1, `SPIEM_IDX_URHI, 16'hC3A5);
    bus(0, `SPIEM_IDX_URLO, 16'h0000); chk_val(rdq, 32'h0000_5A3D);
    bus(0, `SPIEM_IDX_URHI, 16'h0000); chk_val(rdq, 32'h0000_C3A5);
    bus(1, 12'h100, 16'hFFFF);
    bus(0, 12'h100, 16'h0000); chk_val(rdq, 32'h0000_0000);
  endtask
  task automatic events_check;
    bus(1, `SPIEM_IDX_EVEN, 16'h0008); tick(4); chk_bit(irq_event, 1'b1);
    bus(1, `SPIEM_IDX_EVEN, 16'h0000); tick(4); chk_bit(irq_event, 1'b0);
    bus(1, `SPIEM_IDX_EVEN, 16'h0002);
    pulse(4'b1000); chk_bit(tx_buffer_full_flag, 1'b1);
    chk_bit(tx_buffer_empty_flag, 1'b0); chk_bit(irq_event, 1'b1);
    bus(1, `SPIEM_IDX_EVEN, 16'h0000); tick(4); chk_bit(irq_event, 1'b0);
    pulse(4'b0100); chk_bit(tx_buffer_full_flag, 1'b0);
    bus(1, `SPIEM_IDX_EVEN, 16'h0001);
    pulse(4'b0010); chk_bit(rx_buffer_full_flag, 1'b1); chk_bit(irq_event, 1'b1);
    pulse(4'b0001); chk_bit(rx_buffer_full_flag, 1'b0); chk_bit(irq_event, 1'b0);
    bus(1, `SPIEM_IDX_EVEN, 16'h0000);
  endtask
  task automatic wm_check;
    bus(1, `SPIEM_IDX_CTRL, 16'h0001);
    bus(1, `SPIEM_IDX_WMCTL, 16'h8300);
    repeat (2) pulse(4'b0010);
    chk_bit(irq_event, 1'b0);
    pulse(4'b0010); chk_bit(irq_event, 1'b1);
    pulse(4'b0010); chk_bit(irq_event, 1'b1);
    chk_val({26'h0, rx_element_count}, 32'h4);
    bus(0, `SPIEM_IDX_STATH, 16'h0000); chk_val(rdq, 32'h0000_0400);
    bus(1, `SPIEM_IDX_WMCTL, 16'h0300); tick(4); chk_bit(irq_event, 1'b0);
    repeat (4) pulse(4'b0001);
    bus(1, `SPIEM_IDX_WMCTL, 16'h0082);
    repeat (2) pulse(4'b1000);
    chk_bit(irq_event, 1'b1);
    pulse(4'b1000); chk_bit(irq_event, 1'b0);
    chk_val({26'h0, tx_element_count}, 32'h3);
    repeat (6) pulse(4'b1000);
    chk_val({26'h0, tx_element_count}, 32'h8); chk_bit(tx_buffer_full_flag, 1'b1);
    bus(0, `SPIEM_IDX_FLAGS, 16'h0000); chk_val(rdq, 32'h0000_0002);
    repeat (8) pulse(4'b0100);
    chk_val({26'h0, tx_element_count}, 32'h0); chk_bit(tx_buffer_empty_flag, 1'b1);
    bus(1, `SPIEM_IDX_WMCTL, 16'h0000);
    bus(1, `SPIEM_IDX_CTRL, 16'h0000);
  endtask
  task automatic irq_check;
    bus(0, `SPIEM_IDX_ISTAT, 16'h0000);
    bus(1, `SPIEM_IDX_EVEN, 16'h0001);
    bus(1, `SPIEM_IDX_IMASK, 16'h0001); chk_bit(irq, 1'b0);
    pulse(4'b0010); chk_bit(irq, 1'b1);
    pulse(4'b0001); chk_bit(irq, 1'b1);
    bus(0, `SPIEM_IDX_ISTAT, 16'h0000); chk_val(rdq & 32'h1, 32'h1);
    tick(3); chk_bit(irq, 1'b0);
    bus(0, `SPIEM_IDX_ISTAT, 16'h0000); chk_val(rdq & 32'h1, 32'h0);
    bus(1, `SPIEM_IDX_IMASK, 16'h0000);
    pulse(4'b0010); chk_bit(irq, 1'b0);
    pulse(4'b0001);
    bus(0, `SPIEM_IDX_ISTAT, 16'h0000); chk_val(rdq & 32'h1, 32'h1);
    bus(1, `SPIEM_IDX_EVEN, 16'h0000);
  endtask
  // select, raise one underrun strobe and let the far side clock out n bits
  task automatic frame(input int n);
    int i;
    nbits <= n[5:0];
    go <= 1'b1;
    tick(4);
    tx_underrun_flag <= 1'b1;
    go <= 1'b0;
    @(posedge clk);
    tx_underrun_flag <= 1'b0;
    for (i = 0; i < 1000 && done !== 1'b1; i++) @(posedge clk);
    if (i == 1000) begin
      n_errors++;
      tally_and_finish;
    end
    tick(2);
  endtask
  task automatic underrun_check;
    logic [4:0] fld[5] = '{5'h01, 5'h07, 5'h0F, 5'h17, 5'h00};
    int         nb[5] = '{2, 8, 16, 24, 32};
    bus(1, `SPIEM_IDX_EVEN, 16'h0100);
    for (int k = 0; k < 5; k++) begin
      bus(1, `SPIEM_IDX_CTRL, {3'h0, fld[k], 8'h02});
      frame(nb[k]); chk_bit(drove, 1'b1);
      chk_val(got, 32'hC3A5_5A3D & (32'hFFFF_FFFF >> (32 - nb[k])));
      chk_bit(sdo_oe_n, 1'b1);
    end
    bus(0, `SPIEM_IDX_ISTAT, 16'h0000); chk_val(rdq & 32'h0000_0100, 32'h0000_0100);
    bus(1, `SPIEM_IDX_EVEN, 16'h0000);
    bus(1, `SPIEM_IDX_CTRL, 16'h0700);
    frame(8); chk_bit(drove, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, tx_push, tx_pop, rx_push, rx_pop} = 6'h00;
    {tx_underrun_flag, go} = 2'h0;
    avs_address = 14'h0000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    nbits = 6'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    regs_check;
    events_check;
    wm_check;
    irq_check;
    underrun_check;
    tally_and_finish;
  end
endmodule // test_spi_event_mask_and_underrun_data
